// ===== dv/spims_far.sv
// far-side spi device: slave to a dut master, master to a dut slave
`timescale 1ns/100ps
module spims_far (
   // link clock and shared clock mode
   input  wire logic lclk_in,
   input  wire logic cpol_in,
   input  wire logic cpha_in,
   // dut pins seen
   input  wire logic en_in,
   input  wire logic dut_sck_in,
   input  wire logic dut_mosi_in,
   input  wire logic dut_miso_in,
   // pins driven
   output logic      sck_out,
   output logic      mosi_out,
   output logic      miso_out,
   output logic      nss_n_out
);
   localparam int HALF = 84; // 504 ns half period, just over five clk periods
   logic [7:0] sr;
   logic [7:0] s_rx;
   logic [7:0] m_rx;
   initial begin
      {sck_out, mosi_out, miso_out, nss_n_out} = 4'h1;
   end
   // ==========================================================
   // slave side: same phase and polarity as the dut
   always @(dut_sck_in) begin
      if (en_in) begin
         if (dut_sck_in == (cpol_in == cpha_in)) s_rx = {s_rx[6:0], dut_mosi_in};
         else begin
            miso_out = sr[7];
            sr = {sr[6:0], ~sr[0]}; // spent bits toggle, never a stale level
         end
      end
   end
   task automatic load(input logic [7:0] b);
      sr = b;
      if (!cpha_in) begin
         miso_out = sr[7];
         sr = {sr[6:0], ~sr[0]};
      end
   endtask : load
   // ==========================================================
   // master side: clock still outside frames
   task automatic xfer(input logic [7:0] tx, input logic sel);
      logic [7:0] m;
      m = tx;
      sck_out = cpol_in;
      repeat (2) @(posedge lclk_in); // idle level settles before select
      nss_n_out = !sel;
      repeat (40) @(posedge lclk_in); // select well over 2 clk before first edge
      if (!cpha_in) begin
         mosi_out = m[7];
         m = m << 1;
      end
      for (int e = 0; e < 16; e++) begin
         repeat (HALF) @(posedge lclk_in);
         sck_out = !sck_out;
         if ((e % 2) == cpha_in) m_rx = {m_rx[6:0], dut_miso_in};
         else begin
            mosi_out = m[7];
            m = m << 1;
         end
      end
      repeat (HALF) @(posedge lclk_in);
      nss_n_out = 1'b1;
      mosi_out = !mosi_out; // released line does not keep its value
   endtask : xfer
endmodule : spims_far

// ===== dv/spims_port_assertions.sv
// port checker for the serial port unit
`timescale 1ns/100ps
module spims_port_chk
   import spims_pkg::*;
(
   // clock, reset, controls
   input  wire logic                    clk_in,
   input  wire logic                    resetn_in,
   input  wire logic                    ctrl_write_in,
   input  wire logic                    data_write_in,
   input  wire logic                    int_enable_in,
   input  wire logic [1:0]              select_mode_in,
   input  wire logic                    slave_select_pin_in,
   input  wire logic [SPIMS_NFLAGS-1:0] flag_clear_in,
   // observed outputs
   input  wire logic [7:0]              rx_data_out,
   input  wire logic                    rx_full_out,
   input  wire logic                    tx_full_out,
   input  wire logic                    busy_out,
   input  wire logic                    master_enable_out,
   input  wire logic                    port_enable_out,
   input  wire logic [SPIMS_NFLAGS-1:0] flags_out,
   input  wire logic                    irq_out,
   input  wire logic                    miso_oe_out,
   input  wire logic                    slave_select_pin_out,
   input  wire logic                    slave_select_pin_oe_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // ==========================================================
   // assertions
   AST_IRQ:
      assert property (irq_out == (int_enable_in && (|flags_out))) else $error("irq wrong");
   AST_NO_AUTO_CLEAR:
      assert property (!(|($past(flags_out) & ~flags_out & ~$past(flag_clear_in))))
      else $error("flag cleared without request");
   AST_MODE_FAULT:
      assert property (master_enable_out && port_enable_out && !slave_select_pin_in &&
         select_mode_in == SPIMS_SSM_MULTI |-> ##[0:4] (!master_enable_out &&
         !port_enable_out && flags_out[SPIMS_FLG_MODE_FAULT_FLAG])) else $error("no mode fault");
   AST_NO_SELF_ENABLE:
      assert property ($rose(port_enable_out) |-> $past(ctrl_write_in))
      else $error("port enabled itself");
   AST_SELECT_OUT:
      assert property (select_mode_in[1] && port_enable_out |-> slave_select_pin_oe_out &&
         slave_select_pin_out == select_mode_in[0]) else $error("select output wrong");
   AST_SELECT_3WIRE:
      assert property (select_mode_in == SPIMS_SSM_3WIRE |-> !slave_select_pin_oe_out)
      else $error("select driven in 3-wire");
   AST_MISO_RELEASE:
      assert property ((!port_enable_out || (select_mode_in == SPIMS_SSM_MULTI &&
         slave_select_pin_in && !master_enable_out))[*4] |-> !miso_oe_out)
      else $error("miso driven while released");
   AST_COLLISION:
      assert property (data_write_in && tx_full_out |=> flags_out[SPIMS_FLG_WRITE_COLLISION_FLAG])
      else $error("no collision flag");
   AST_MASTER_START:
      assert property (data_write_in && !tx_full_out && !busy_out && master_enable_out &&
         port_enable_out |-> ##[1:3] busy_out) else $error("transfer did not start");
   AST_DONE_RX:
      assert property ($rose(flags_out[SPIMS_FLG_DONE]) |-> rx_full_out)
      else $error("done without receive byte");
   AST_OVERRUN_KEEP:
      assert property ($rose(flags_out[SPIMS_FLG_OVR]) |-> rx_full_out && $stable(rx_data_out))
      else $error("overrun changed receive byte");
   COV_DONE:  cover property ($rose(flags_out[SPIMS_FLG_DONE]));
   COV_FAULT: cover property ($rose(flags_out[SPIMS_FLG_MODE_FAULT_FLAG]));
   COV_OVR:   cover property ($rose(flags_out[SPIMS_FLG_OVR]));
endmodule : spims_port_chk

bind spims_port spims_port_chk i_chk (.clk_in, .resetn_in, .ctrl_write_in, .data_write_in,
   .int_enable_in, .select_mode_in, .slave_select_pin_in, .flag_clear_in, .rx_data_out,
   .rx_full_out, .tx_full_out, .busy_out, .master_enable_out, .port_enable_out, .flags_out,
   .irq_out, .miso_oe_out, .slave_select_pin_out, .slave_select_pin_oe_out);

// ===== dv/spims_port_tb.sv
// self-checking bench for the serial port unit
`timescale 1ns/100ps
module spims_port_tb;
   import spims_pkg::*;
   logic clk_in, resetn_in, lclk, ctrl_write_in, master_enable_in, port_enable_in;
   logic clock_phase_bit_in, clock_polarity_bit_in, int_enable_in, data_write_in;
   logic data_read_in, ss_n, rx_full_out, tx_full_out, busy_out, slave_selected_out;
   logic master_enable_out, port_enable_out, irq_out, sck_out, sck_oe_out, mosi_out;
   logic mosi_oe_out, miso_out, miso_oe_out, ss_out, ss_oe, f_sck, f_mosi, f_miso, f_nss;
   logic [1:0] select_mode_in;
   logic [7:0] clock_rate_in, data_in, rx_data_out, sb, mb, m0;
   logic [SPIMS_NFLAGS-1:0] flag_clear_in, flags_out;
   int bad_count, num_checks, tx_q[$];
   initial begin clk_in = 0; forever #50 clk_in = !clk_in; end
   initial begin lclk = 0; #1.3; forever #3 lclk = !lclk; end
   spims_port i_dut (.clk_in, .resetn_in, .ctrl_write_in, .master_enable_in, .port_enable_in,
      .select_mode_in, .clock_phase_bit_in, .clock_polarity_bit_in, .clock_rate_in,
      .int_enable_in, .flag_clear_in, .data_write_in, .data_in, .data_read_in, .rx_data_out,
      .rx_full_out, .tx_full_out, .busy_out, .slave_selected_out, .master_enable_out,
      .port_enable_out, .flags_out, .irq_out, .sck_in(f_sck), .sck_out, .sck_oe_out,
      .mosi_in(f_mosi), .mosi_out, .mosi_oe_out, .miso_in(f_miso), .miso_out, .miso_oe_out,
      .slave_select_pin_in(f_nss & ss_n), .slave_select_pin_out(ss_out),
      .slave_select_pin_oe_out(ss_oe));
   spims_far i_far (.lclk_in(lclk), .cpol_in(clock_polarity_bit_in), .cpha_in(clock_phase_bit_in),
      .en_in(sck_oe_out), .dut_sck_in(sck_out), .dut_mosi_in(mosi_out),
      .dut_miso_in(miso_oe_out ? miso_out : !miso_out), // released miso shows the inverse
      .sck_out(f_sck), .mosi_out(f_mosi), .miso_out(f_miso), .nss_n_out(f_nss));
   // ==========================================================
   // tasks
   task automatic final_report();
      if (bad_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask : cyc
   task automatic ctrl(input logic m, input logic p);
      {ctrl_write_in, master_enable_in, port_enable_in} = {1'b1, m, p};
      cyc(1);
      ctrl_write_in = 1'b0;
      cyc(1);
   endtask : ctrl
   task automatic wr(input logic [7:0] b);
      {data_write_in, data_in} = {1'b1, b};
      cyc(1);
      data_write_in = 1'b0;
   endtask : wr
   task automatic pulse_clr_rd();
      {flag_clear_in, data_read_in} = 5'h1f;
      cyc(1);
      {flag_clear_in, data_read_in} = 5'h00;
   endtask : pulse_clr_rd
   task automatic wait_done();
      int n;
      for (n = 0; n < 3000 && flags_out[SPIMS_FLG_DONE] !== 1'b1; n++) cyc(1);
      if (n >= 3000) begin
         bad_count++; // hang cut short
         final_report();
      end
   endtask : wait_done
   // ==========================================================
   // main sequence
   initial begin
      {resetn_in, ctrl_write_in, master_enable_in, port_enable_in, data_write_in} = 5'h0;
      {data_read_in, clock_phase_bit_in, clock_polarity_bit_in, ss_n} = 4'h1;
      {select_mode_in, clock_rate_in, data_in, flag_clear_in} = '0;
      {int_enable_in, bad_count, num_checks} = '0;
      cyc(5);
      resetn_in = 1'b1;
      void'($urandom(32'h217a311b));
      int_enable_in = 1'b1;
      select_mode_in = 2'h2;
      for (int m = 0; m < 4; m++) begin
         ctrl(1'b1, 1'b0); // mode changed only while disabled
         {clock_polarity_bit_in, clock_phase_bit_in} = 2'(m);
         clock_rate_in = 8'(3 + $urandom_range(2));
         ctrl(1'b1, 1'b1);
         {sb, mb} = 16'($urandom);
         i_far.load(sb);
         wr(mb);
         wait_done();
         chk("rx_data", sb, rx_data_out);
         chk("far_rx", mb, i_far.s_rx);
         chk("flags", 8'h1, {4'h0, flags_out});
         chk("irq", 8'h1, {7'h0, irq_out});
         chk("ss_out", 8'h0, {7'h0, ss_out});
         chk("mosi_oe", 8'h1, {7'h0, mosi_oe_out});
         pulse_clr_rd();
      end
      select_mode_in = 2'h3;
      for (int k = 0; k < 2; k++) begin
         sb = 8'($urandom);
         tx_q.push_back(sb);
         {data_write_in, data_in} = {1'b1, sb};
         cyc(1);
         wr(~sb); // buffer still full, dropped
         chk("write_collision_flag", 8'h1, {7'h0, flags_out[SPIMS_FLG_WRITE_COLLISION_FLAG]});
         pulse_clr_rd();
         cyc(2);
      end
      chk("ss_out", 8'h1, {7'h0, ss_out});
      for (int k = 0; k < 2; k++) begin
         wait_done();
         chk("far_rx", 8'(tx_q.pop_front()), i_far.s_rx);
         pulse_clr_rd();
      end
      select_mode_in = 2'h1;
      ctrl(1'b1, 1'b1);
      ss_n = 1'b0;
      cyc(20);
      chk("enables", 8'h0, {6'h0, master_enable_out, port_enable_out});
      chk("mode_fault_flag", 8'h1, {7'h0, flags_out[SPIMS_FLG_MODE_FAULT_FLAG]});
      ss_n = 1'b1;
      pulse_clr_rd();
      ctrl(1'b1, 1'b1);
      chk("enables", 8'h3, {6'h0, master_enable_out, port_enable_out});
      ctrl(1'b0, 1'b1);
      chk("mosi_oe", 8'h0, {7'h0, mosi_oe_out});
      ss_n = 1'b0;
      cyc(3);
      chk("slave_sel", 8'h1, {7'h0, slave_selected_out});
      ss_n = 1'b1;
      int_enable_in = 1'b0;
      {sb, m0} = 16'($urandom);
      wr(sb);
      i_far.xfer(m0, 1'b1);
      cyc(6);
      chk("rx_data", m0, rx_data_out);
      chk("far_rx", sb, i_far.m_rx);
      chk("irq", 8'h0, {7'h0, irq_out});
      {flag_clear_in} = 4'hf;
      cyc(1);
      flag_clear_in = 4'h0;
      i_far.xfer(8'($urandom), 1'b1);
      cyc(6);
      chk("ovr", 8'h1, {7'h0, flags_out[SPIMS_FLG_OVR]});
      chk("rx_keep", m0, rx_data_out);
      pulse_clr_rd();
      i_far.xfer(8'($urandom), 1'b0);
      cyc(6);
      chk("flags", 8'h0, {4'h0, flags_out});
      select_mode_in = 2'h0;
      ctrl(1'b0, 1'b0);
      ctrl(1'b0, 1'b1);
      {sb, m0} = 16'($urandom);
      wr(sb);
      i_far.xfer(m0, 1'b0);
      cyc(6);
      chk("rx_data", m0, rx_data_out);
      chk("far_rx", sb, i_far.m_rx);
      chk("ss_oe", 8'h0, {7'h0, ss_oe});
      final_report();
   end
endmodule : spims_port_tb

// ===== rtl/spims_pkg.sv
// shared constants for the serial port unit
package spims_pkg;
   // ======================================================
   // byte framing
   localparam int          SPIMS_BITS      = 8;
   localparam logic [3:0]  SPIMS_LAST_EDGE = 4'hf;
   localparam logic [2:0]  SPIMS_LAST_BIT  = 3'h7;
   // ======================================================
   // select modes (select_mode_high, select_mode_low)
   localparam logic [1:0]  SPIMS_SSM_3WIRE = 2'h0;
   localparam logic [1:0]  SPIMS_SSM_MULTI = 2'h1;
   // ======================================================
   // flag positions
   localparam int          SPIMS_NFLAGS    = 4;
   localparam int          SPIMS_FLG_DONE  = 0;
   localparam int          SPIMS_FLG_WRITE_COLLISION_FLAG  = 1;
   localparam int          SPIMS_FLG_MODE_FAULT_FLAG  = 2;
   localparam int          SPIMS_FLG_OVR   = 3;
   // ======================================================
   // reset values
   localparam logic [7:0]  SPIMS_DATA_RST  = 8'h00;
   localparam logic [3:0]  SPIMS_FLAG_RST  = 4'h0;
   // ======================================================
   // timing: master bit rate ceiling
   localparam longint      SPIMS_SYS_HZ    = 10_000_000;
   localparam longint      SPIMS_MAX_HZ    = 12_500_000;
   localparam longint      SPIMS_RATE_HZ   = (SPIMS_SYS_HZ / 2 < SPIMS_MAX_HZ) ?
                                             SPIMS_SYS_HZ / 2 : SPIMS_MAX_HZ;
   localparam longint      SPIMS_HALF_CALC = (SPIMS_SYS_HZ + 2 * SPIMS_RATE_HZ - 1) /
                                             (2 * SPIMS_RATE_HZ);
   localparam logic [8:0]  SPIMS_MIN_HALF  = (SPIMS_HALF_CALC < 1) ? 9'h001 :
                                             9'(SPIMS_HALF_CALC);
   // ======================================================
   // master sequencer
   typedef enum logic {SPIMS_IDLE, SPIMS_RUN} spims_state_t;
endpackage : spims_pkg

// ===== rtl/spims_port.sv
// serial port unit: master/slave spi byte port
// How it works
// - master write fills buffer, starts if idle
// - master shifts out, sets done flag
// - input bits msb first into receive buffer
// - multi-master select low drops enables, faults
// - after fault, stays off until rewritten
// - mode 00 is 3-wire, select unused
// - mode 1x drives select from low bit
// - slave counts sampling edges, done after eight
// - slave writes load when shift empty
// - shift frozen once slave transfer starts
// - 4-wire slave ignores bus when deselected
// - 3-wire slave counter reset by re-enable
// - write while buffer full collides, discarded
// - slave overrun keeps old byte
// - four flags request interrupt, software clears
// - phase and polarity give four modes
// - both ends share phase and polarity
// - clock rate used only as master
// - master rate capped at half clock
// - idle clock level follows polarity
// - miso released when disabled or deselected
`timescale 1ns/100ps
module spims_port
   import spims_pkg::*;
(
   // system clock and reset
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   // control and configuration
   input  wire logic        ctrl_write_in,
   input  wire logic        master_enable_in,
   input  wire logic        port_enable_in,
   input  wire logic [1:0]  select_mode_in,
   input  wire logic        clock_phase_bit_in,
   input  wire logic        clock_polarity_bit_in,
   input  wire logic [7:0]  clock_rate_in,
   input  wire logic        int_enable_in,
   input  wire logic [SPIMS_NFLAGS-1:0] flag_clear_in,
   // data register
   input  wire logic        data_write_in,
   input  wire logic [7:0]  data_in,
   input  wire logic        data_read_in,
   output logic [7:0]       rx_data_out,
   // status
   output logic             rx_full_out,
   output logic             tx_full_out,
   output logic             busy_out,
   output logic             slave_selected_out,
   output logic             master_enable_out,
   output logic             port_enable_out,
   output logic [SPIMS_NFLAGS-1:0] flags_out,
   output logic             irq_out,
   // serial clock pin
   input  wire logic        sck_in,
   output logic             sck_out,
   output logic             sck_oe_out,
   // data pins
   input  wire logic        mosi_in,
   output logic             mosi_out,
   output logic             mosi_oe_out,
   input  wire logic        miso_in,
   output logic             miso_out,
   output logic             miso_oe_out,
   // slave select pin
   input  wire logic        slave_select_pin_in,
   output logic             slave_select_pin_out,
   output logic             slave_select_pin_oe_out
);
   import spims_pkg::*;

   // ======================================================
   // declarations
   spims_state_t            state_ff;
   logic                    master_en_ff;
   logic                    port_en_ff;
   logic [7:0]              tx_buf_ff;
   logic                    tx_full_ff;
   logic [7:0]              rx_buf_ff;
   logic                    rx_full_ff;
   logic [SPIMS_NFLAGS-1:0] flags_ff;
   logic [SPIMS_NFLAGS-1:0] nxt_flags;
   logic [7:0]              m_tx_sh_ff;
   logic [7:0]              m_rx_sh_ff;
   logic                    m_mosi_ff;
   logic                    m_sck_ff;
   logic [3:0]              m_edge_ff;
   logic [8:0]              m_div_ff;
   logic                    m_done_ff;
   logic                    s_shift_full_ff;
   logic [7:0]              s_load_ff;
   logic                    miso_s1_ff;
   logic                    miso_s2_ff;
   logic                    nss_s1_ff;
   logic                    nss_s2_ff;
   logic                    busy_s1_ff;
   logic                    busy_s2_ff;
   logic                    done_s1_ff;
   logic                    done_s2_ff;
   logic                    done_s3_ff;
   logic [2:0]              l_cnt_ff;
   logic [7:0]              l_rx_sh_ff;
   logic [7:0]              l_word_ff;
   logic [7:0]              l_tx_sh_ff;
   logic                    l_done_tgl_ff;
   logic                    master_act;
   logic                    slave_act;
   logic                    multi_mode;
   logic                    selected;
   logic                    mode_fault;
   logic                    m_tick;
   logic [8:0]              m_half;
   logic                    move_m;
   logic                    move_s;
   logic                    s_done;
   logic                    any_done;
   logic                    write_collision_flag;
   logic                    sck_eff;
   logic                    link_rstn;

   // ======================================================
   // mode decode
   assign master_act = port_en_ff & master_en_ff;
   assign slave_act  = port_en_ff & ~master_en_ff;
   assign multi_mode = (select_mode_in == SPIMS_SSM_MULTI);
   // only the multi mode uses the pin as a select; 3-wire is always selected
   assign selected   = ~(multi_mode & nss_s2_ff);
   assign mode_fault = master_act & multi_mode & ~nss_s2_ff;

   // ======================================================
   // pin synchronisers
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         miso_s1_ff <= 1'b0;
         miso_s2_ff <= 1'b0;
         nss_s1_ff  <= 1'b1;
         nss_s2_ff  <= 1'b1;
      end else begin
         miso_s1_ff <= miso_in;
         miso_s2_ff <= miso_s1_ff;
         nss_s1_ff  <= slave_select_pin_in;
         nss_s2_ff  <= nss_s1_ff;
      end
   end

   // ======================================================
   // enables: software sets, a mode fault clears and wins
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         master_en_ff <= 1'b0;
         port_en_ff   <= 1'b0;
      end else if (mode_fault) begin
         master_en_ff <= 1'b0;
         port_en_ff   <= 1'b0;
      end else if (ctrl_write_in) begin
         master_en_ff <= master_enable_in;
         port_en_ff   <= port_enable_in;
      end
   end

   // ======================================================
   // transmit buffer
   assign move_m = (state_ff == SPIMS_IDLE) & master_act & tx_full_ff;
   // shift register is frozen while the link is mid-byte
   assign move_s = slave_act & tx_full_ff & ~s_shift_full_ff & ~busy_s2_ff
                   & ~s_done;
   assign write_collision_flag   = data_write_in & tx_full_ff;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_buf_ff  <= SPIMS_DATA_RST;
         tx_full_ff <= 1'b0;
      end else if (data_write_in && !tx_full_ff) begin
         tx_buf_ff  <= data_in;
         tx_full_ff <= 1'b1;
      end else if (move_m || move_s) begin
         tx_full_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_shift_full_ff <= 1'b0;
         s_load_ff       <= SPIMS_DATA_RST;
      end else if (!slave_act || s_done) begin
         s_shift_full_ff <= 1'b0;
      end else if (move_s) begin
         s_shift_full_ff <= 1'b1;
         s_load_ff       <= tx_buf_ff;
      end
   end

   // ======================================================
   // master sequencer
   // half period never below the rate ceiling
   assign m_half = ({1'b0, clock_rate_in} + 9'h001 < SPIMS_MIN_HALF) ? SPIMS_MIN_HALF :
                   {1'b0, clock_rate_in} + 9'h001;
   assign m_tick = (state_ff == SPIMS_RUN) & (m_div_ff + 9'h001 >= m_half);

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_ff <= SPIMS_IDLE;
         m_div_ff <= 9'h000;
      end else if (!master_act) begin
         state_ff <= SPIMS_IDLE;
         m_div_ff <= 9'h000;
      end else if (move_m) begin
         state_ff <= SPIMS_RUN;
         m_div_ff <= 9'h000;
      end else if (m_tick) begin
         m_div_ff <= 9'h000;
         if (m_edge_ff == SPIMS_LAST_EDGE) begin
            state_ff <= SPIMS_IDLE;
         end
      end else if (state_ff == SPIMS_RUN) begin
         m_div_ff <= m_div_ff + 9'h001;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         m_sck_ff   <= 1'b0;
         m_edge_ff  <= 4'h0;
         m_tx_sh_ff <= SPIMS_DATA_RST;
         m_rx_sh_ff <= SPIMS_DATA_RST;
         m_mosi_ff  <= 1'b0;
      end else if (state_ff == SPIMS_IDLE) begin
         m_sck_ff  <= clock_polarity_bit_in;
         m_edge_ff <= 4'h0;
         if (move_m && !clock_phase_bit_in) begin
            m_mosi_ff  <= tx_buf_ff[7];
            m_tx_sh_ff <= {tx_buf_ff[6:0], 1'b0};
         end else if (move_m) begin
            m_tx_sh_ff <= tx_buf_ff;
         end
      end else if (m_tick) begin
         m_sck_ff  <= ~m_sck_ff;
         m_edge_ff <= m_edge_ff + 4'h1;
         // phase picks leading or trailing edge for sampling
         if (m_edge_ff[0] == clock_phase_bit_in) begin
            m_rx_sh_ff <= {m_rx_sh_ff[6:0], miso_s2_ff};
         end else if (m_edge_ff != SPIMS_LAST_EDGE) begin
            m_mosi_ff  <= m_tx_sh_ff[7];
            m_tx_sh_ff <= {m_tx_sh_ff[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         m_done_ff <= 1'b0;
      end else begin
         m_done_ff <= m_tick & (m_edge_ff == SPIMS_LAST_EDGE);
      end
   end

   // ======================================================
   // slave link domain (runs on the master's clock)
   // sampling edge becomes the rising edge for all four modes
   assign sck_eff   = sck_in ^ clock_polarity_bit_in ^ clock_phase_bit_in;
   // a high select in multi mode, a disabled port or master mode holds the counter at zero
   assign link_rstn = resetn_in & slave_act & selected_raw();

   function automatic logic selected_raw();
      selected_raw = ~(multi_mode & slave_select_pin_in);
   endfunction : selected_raw

   always_ff @(posedge sck_eff or negedge link_rstn) begin
      if (!link_rstn) begin
         l_cnt_ff   <= 3'h0;
         l_rx_sh_ff <= SPIMS_DATA_RST;
      end else begin
         l_cnt_ff   <= l_cnt_ff + 3'h1;
         l_rx_sh_ff <= {l_rx_sh_ff[6:0], mosi_in};
      end
   end

   // toggle and word survive the link reset so the other side sees no false event
   always_ff @(posedge sck_eff or negedge resetn_in) begin
      if (!resetn_in) begin
         l_done_tgl_ff <= 1'b0;
         l_word_ff     <= SPIMS_DATA_RST;
      end else if (link_rstn && l_cnt_ff == SPIMS_LAST_BIT) begin
         l_done_tgl_ff <= ~l_done_tgl_ff;
         l_word_ff     <= {l_rx_sh_ff[6:0], mosi_in};
      end
   end

   always_ff @(negedge sck_eff or negedge link_rstn) begin
      if (!link_rstn) begin
         l_tx_sh_ff <= SPIMS_DATA_RST;
      end else if (l_cnt_ff == 3'h0) begin
         l_tx_sh_ff <= s_load_ff;
      end else if (l_cnt_ff == 3'h1 && !clock_phase_bit_in) begin
         l_tx_sh_ff <= {s_load_ff[6:0], 1'b0};
      end else begin
         l_tx_sh_ff <= {l_tx_sh_ff[6:0], 1'b0};
      end
   end

   // ======================================================
   // crossing back to the system clock
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         busy_s1_ff <= 1'b0;
         busy_s2_ff <= 1'b0;
         done_s1_ff <= 1'b0;
         done_s2_ff <= 1'b0;
         done_s3_ff <= 1'b0;
      end else begin
         busy_s1_ff <= (l_cnt_ff != 3'h0);
         busy_s2_ff <= busy_s1_ff;
         done_s1_ff <= l_done_tgl_ff;
         done_s2_ff <= done_s1_ff;
         done_s3_ff <= done_s2_ff;
      end
   end

   assign s_done   = slave_act & (done_s2_ff ^ done_s3_ff);
   assign any_done = m_done_ff | s_done;

   // ======================================================
   // receive buffer
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rx_buf_ff  <= SPIMS_DATA_RST;
         rx_full_ff <= 1'b0;
      end else if (m_done_ff) begin
         rx_buf_ff  <= m_rx_sh_ff;
         rx_full_ff <= 1'b1;
      end else if (s_done && (!rx_full_ff || data_read_in)) begin
         rx_buf_ff  <= l_word_ff;
         rx_full_ff <= 1'b1;
      end else if (data_read_in) begin
         rx_full_ff <= 1'b0;
      end
   end

   // ======================================================
   // flags: hardware set wins over software clear
   always_comb begin
      nxt_flags = flags_ff & ~flag_clear_in;
      if (any_done) begin
         nxt_flags[SPIMS_FLG_DONE] = 1'b1;
      end
      if (write_collision_flag) begin
         nxt_flags[SPIMS_FLG_WRITE_COLLISION_FLAG] = 1'b1;
      end
      if (mode_fault) begin
         nxt_flags[SPIMS_FLG_MODE_FAULT_FLAG] = 1'b1;
      end
      if (s_done && rx_full_ff && !data_read_in) begin
         nxt_flags[SPIMS_FLG_OVR] = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         flags_ff <= SPIMS_FLAG_RST;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   // ======================================================
   // pins
   assign sck_out                 = m_sck_ff;
   assign sck_oe_out              = master_act;
   assign mosi_out                = m_mosi_ff;
   assign mosi_oe_out             = master_act;
   // miso shows the load register msb at count zero, then the link shift register, msb first
   assign miso_out                = (l_cnt_ff == 3'h0) ? s_load_ff[7] : l_tx_sh_ff[7];
   assign miso_oe_out             = slave_act & selected;
   assign slave_select_pin_out    = select_mode_in[0];
   assign slave_select_pin_oe_out = port_en_ff & select_mode_in[1];

   // ======================================================
   // status
   assign rx_data_out        = rx_buf_ff;
   assign rx_full_out        = rx_full_ff;
   assign tx_full_out        = tx_full_ff;
   assign busy_out           = (state_ff == SPIMS_RUN) | (slave_act & busy_s2_ff);
   assign slave_selected_out = slave_act & ~nss_s2_ff & multi_mode;
   assign master_enable_out  = master_en_ff;
   assign port_enable_out    = port_en_ff;
   assign flags_out          = flags_ff;
   assign irq_out            = int_enable_in & (|flags_ff);
endmodule : spims_port
